/* rtl/serial_bit_memory.sv */
// sequencer, bit store, capture fifo and register slave
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`include "serial_bit_memory_cfg.svh"

module capture_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input  wire logic             clock,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;
	assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) &&
		(wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data  = store[rd_ptr[AW-1:0]];
	always_ff @(posedge clock) begin
		if (push)
			store[wr_ptr[AW-1:0]] <= in_data;
	end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule // capture_fifo

module serial_bit_memory #(
	parameter int REFRESH_TICK = `REFRESH_TICKS,
	parameter int FIFO_DEPTH   = `FIFO_DEPTH
) (
	input  wire logic        CLOCK,
	input  wire logic        NRST,
	input  wire logic        RW_STROBE_N,
	input  wire logic        WRITE_SELECT_N,
	input  wire logic        DATA_IN,
	output logic             DATA_OUT,
	output logic             DATA_OUT_EN,
	input  wire logic        SERIAL_ADDR_IN,
	input  wire logic        SERIAL_ADDR_STROBE,
	input  wire logic        ADDR_TRANSFER_STROBE_N,
	input  wire logic        COUNT_DIRECTION_SELECT,
	input  wire logic        REFRESH_MODE_SELECT_N,
	input  wire logic        EXT_REFRESH_STROBE_N,
	input  wire logic        FAST_ACCESS_SELECT_N,
	output serial_bit_memory_pkg::status_t STATUS,
	input  wire logic [3:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [3:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY
);
	import serial_bit_memory_pkg::*;
	localparam int DEPTH = 1 << (`ROW_BITS + `WORD_BITS);
	localparam int TW    = $clog2(REFRESH_TICK + 1);

	logic                   bits [0:DEPTH-1];
	mem_addr_t              addr;
	logic [`SHIFT_BITS-1:0] shift_addr;
	logic                   count_up;
	logic                   fast;
	logic                   row_pending;
	logic                   rw_prev;
	logic                   xfer_prev;
	logic                   shift_prev;
	logic                   rf_prev;
	logic [TW-1:0]          tick;
	logic [9:0]             refresh_row;
	logic                   capture;
	logic                   overrun;

	// edge detection on inputs taken as synchronous
	wire rw_fall    = rw_prev && !RW_STROBE_N;
	wire xfer_fall  = xfer_prev && !ADDR_TRANSFER_STROBE_N;
	wire shift_rise = !shift_prev && SERIAL_ADDR_STROBE;
	wire rf_fall    = rf_prev && !EXT_REFRESH_STROBE_N;
	wire self_mode  = !REFRESH_MODE_SELECT_N;
	// a transfer in the same edge as a cycle takes priority
	wire cycle      = rw_fall && !xfer_fall;
	wire do_read  = cycle && WRITE_SELECT_N;
	wire word_end = count_up ? (addr.word == `WORD_LAST)
		: (addr.word == `WORD_FIRST);
	wire row_step = cycle && ((word_end && !fast) ||
		(row_pending && !fast));
	wire [`WORD_BITS-1:0] next_word = count_up ? addr.word + 1'b1
		: addr.word - 1'b1;
	wire [`ROW_BITS-1:0]  next_row  = count_up ? addr.row + 1'b1
		: addr.row - 1'b1;
	wire tick_done = tick == TW'(REFRESH_TICK - 1);
	wire refresh_step = self_mode ? tick_done : (rf_fall && RW_STROBE_N);

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			rw_prev    <= 1'b1;
			xfer_prev  <= 1'b1;
			shift_prev <= 1'b0;
			rf_prev    <= 1'b1;
		end else begin
			rw_prev    <= RW_STROBE_N;
			xfer_prev  <= ADDR_TRANSFER_STROBE_N;
			shift_prev <= SERIAL_ADDR_STROBE;
			rf_prev    <= EXT_REFRESH_STROBE_N;
		end
	end

	// serial row load, first bit ends lowest
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST)
			shift_addr <= '0;
		else if (shift_rise)
			shift_addr <= {SERIAL_ADDR_IN, shift_addr[`SHIFT_BITS-1:1]};
	end

	// mode only latched while the strobe is low
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST)
			fast <= 1'b0;
		else if (!RW_STROBE_N)
			fast <= !FAST_ACCESS_SELECT_N;
	end

	// direction follows the pin unless fast
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST)
			count_up <= 1'b1;
		else if (!fast)
			count_up <= COUNT_DIRECTION_SELECT;
	end

	// transfer load, word step, row step on wrap
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			addr        <= '0;
			row_pending <= 1'b0;
		end else if (xfer_fall) begin
			addr.row    <= shift_addr[`ROW_BITS-1:0];
			addr.word   <= count_up ? `WORD_FIRST : `WORD_LAST;
			row_pending <= 1'b0;
		end else if (cycle) begin
			addr.word <= next_word;
			if (row_step)
				addr.row <= next_row;
			// fast wrap owes a row step to the next normal cycle
			row_pending <= fast && (word_end || row_pending);
		end
	end

	// one bit written per write cycle
	always_ff @(posedge CLOCK) begin
		if (cycle && !WRITE_SELECT_N)
			bits[addr] <= DATA_IN;
	end

	// read bit held on the pin until the strobe rises
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			DATA_OUT    <= 1'b0;
			DATA_OUT_EN <= 1'b0;
		end else if (do_read) begin
			DATA_OUT    <= bits[addr];
			DATA_OUT_EN <= 1'b1;
		end else if (RW_STROBE_N || (cycle && !WRITE_SELECT_N)) begin
			DATA_OUT_EN <= 1'b0;
		end
	end

	// refresh row stepped by timer or host strobe
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			tick        <= '0;
			refresh_row <= '0;
		end else begin
			tick <= (tick_done || !self_mode) ? '0 : tick + 1'b1;
			if (refresh_step)
				refresh_row <= refresh_row + 1'b1;
		end
	end

	// read bits captured for software; full fifo drops the bit
	logic fifo_ready;
	logic fifo_valid;
	logic fifo_bit;
	wire  push_bit = do_read && capture;
	wire  ar_take  = S_AXI_ARVALID && S_AXI_ARREADY;
	wire  pop_bit  = ar_take && (S_AXI_ARADDR == `OFS_DATA);

	capture_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) fifo (
		.clock    (CLOCK),
		.nrst     (NRST),
		.in_valid (push_bit),
		.in_ready (fifo_ready),
		.in_data  (bits[addr]),
		.out_valid(fifo_valid),
		.out_ready(pop_bit),
		.out_data (fifo_bit)
	);

	assign STATUS = '{self_refresh: self_mode, overrun: overrun,
		fast: fast, count_up: count_up, addr: addr};

	// write side: address and data taken in either order
	logic        aw_held;
	logic        w_held;
	logic [3:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	wire  do_write  = aw_held && w_held && !S_AXI_BVALID;
	wire  wr_ctrl   = do_write && (aw_addr == `OFS_CTRL);
	wire  wr_status = do_write && (aw_addr == `OFS_STATUS);
	wire  wr_mapped = wr_ctrl || wr_status;
	assign S_AXI_AWREADY = !aw_held;
	assign S_AXI_WREADY  = !w_held;
	assign S_AXI_ARREADY = !S_AXI_RVALID;

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= '0;
			w_data       <= '0;
			w_strb       <= '0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= `RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && !w_held) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			if (do_write) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
			end else if (S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end

	// overrun: a dropped bit in the clearing cycle keeps the flag
	wire drop = push_bit && !fifo_ready;
	wire clr  = wr_status && w_strb[`STRB_STATUS_LANE] &&
		w_data[`STATUS_OVERRUN];
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			capture <= 1'b0;
			overrun <= 1'b0;
		end else begin
			if (wr_ctrl && w_strb[`STRB_CTRL_LANE])
				capture <= w_data[`CTRL_CAPTURE];
			overrun <= drop || (overrun && !clr);
		end
	end

	wire [31:0] rd_word =
		(S_AXI_ARADDR == `OFS_CTRL)    ? {31'h0, capture} :
		(S_AXI_ARADDR == `OFS_STATUS)  ? {10'h0, STATUS} :
		(S_AXI_ARADDR == `OFS_REFRESH) ? {22'h0, refresh_row} :
		{fifo_valid, 30'h0, fifo_bit && fifo_valid};
	wire rd_mapped = S_AXI_ARADDR[1:0] == 2'h0;

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= '0;
			S_AXI_RRESP  <= `RESP_OKAY;
		end else if (ar_take) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= rd_mapped ? rd_word : 32'h0;
			S_AXI_RRESP  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (S_AXI_RREADY)
			S_AXI_RVALID <= 1'b0;
	end

	default clocking @(posedge CLOCK); endclocking
	default disable iff (!NRST);

	a_word_step_up: assert property (
		cycle && count_up |=> addr.word == $past(addr.word) + 10'h1)
		else $error("word did not step up");
	a_word_step_down: assert property (
		cycle && !count_up |=> addr.word == $past(addr.word) - 10'h1)
		else $error("word did not step down");
	a_transfer_load: assert property (
		xfer_fall |=> addr.row == $past(shift_addr[`ROW_BITS-1:0]) &&
		addr.word == ($past(count_up) ? `WORD_FIRST : `WORD_LAST))
		else $error("transfer load wrong");
	a_fast_dir_hold: assert property (
		fast && $past(fast) |-> $stable(count_up))
		else $error("direction changed in fast mode");
	a_row_wrap_up: assert property (
		cycle && !fast && count_up && addr.word == 10'h3ff
		|=> addr.row == $past(addr.row) + 8'h1 && addr.word == 10'h0)
		else $error("row did not step on wrap");
	a_self_refresh: assert property (
		self_mode && tick_done ##1 self_mode
		|-> refresh_row == $past(refresh_row) + 10'h1)
		else $error("self refresh did not step");
	a_write_store: assert property (
		cycle && !WRITE_SELECT_N |=> bits[$past(addr)] == $past(DATA_IN))
		else $error("write bit not stored");
	a_read_drive: assert property (
		do_read |=> DATA_OUT_EN && DATA_OUT == bits[$past(addr)])
		else $error("read bit not driven");
endmodule // serial_bit_memory

/* rtl/serial_bit_memory_cfg.svh */
// constants of the serial bit memory sequencer
`ifndef SERIAL_BIT_MEMORY_CFG_SVH
`define SERIAL_BIT_MEMORY_CFG_SVH
`define WORD_BITS         10
`define ROW_BITS          8
`define SHIFT_BITS        10
`define WORD_LAST         10'h3ff
`define WORD_FIRST        10'h000
`define CLOCK_PERIOD_NS   20
`define REFRESH_PERIOD_NS 100000000
`define REFRESH_ROWS      1024
`define REFRESH_TICKS     (`REFRESH_PERIOD_NS / \
	(`REFRESH_ROWS * `CLOCK_PERIOD_NS))
`define FIFO_DEPTH        16
`define OFS_CTRL          4'h0
`define OFS_STATUS        4'h4
`define OFS_REFRESH       4'h8
`define OFS_DATA          4'hc
`define CTRL_CAPTURE      0
`define STATUS_OVERRUN    20
`define DATA_VALID        31
`define STRB_CTRL_LANE    0
`define STRB_STATUS_LANE  2
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

/* rtl/serial_bit_memory_pkg.sv */
// types shared by the serial bit memory sequencer
package serial_bit_memory_pkg;
	typedef struct packed {
		logic [7:0] row;
		logic [9:0] word;
	} mem_addr_t;
	typedef struct packed {
		logic       self_refresh;
		logic       overrun;
		logic       fast;
		logic       count_up;
		mem_addr_t  addr;
	} status_t;
endpackage

/* tb/host_model.sv */
// host model driving strobes, address and data pins
`timescale 1ns/10ps
module host_model (
	input  wire logic clock,
	input  wire logic data_out,
	input  wire logic data_out_en,
	output logic      rw_strobe_n,
	output logic      write_select_n,
	output logic      data_in,
	output logic      serial_addr_in,
	output logic      serial_addr_strobe,
	output logic      addr_transfer_strobe_n,
	output logic      count_direction_select,
	output logic      refresh_mode_select_n,
	output logic      ext_refresh_strobe_n,
	output logic      fast_access_select_n
);
	initial begin
		{rw_strobe_n, write_select_n, addr_transfer_strobe_n} = 3'h7;
		{ext_refresh_strobe_n, fast_access_select_n} = 2'h3;
		{data_in, serial_addr_in, serial_addr_strobe} = 3'h0;
		count_direction_select = 1'h1;
		refresh_mode_select_n = 1'h0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic load(input logic [9:0] a);
		for (int i = 0; i < 10; i++) begin
			serial_addr_in <= a[i];
			tick(2);
			serial_addr_strobe <= 1'h1;
			tick(2);
			serial_addr_strobe <= 1'h0;
			tick(2);
		end
		addr_transfer_strobe_n <= 1'h0;
		tick(2);
		addr_transfer_strobe_n <= 1'h1;
		tick(3);
	endtask
	// fast select moves only while strobe low
	task automatic access(input logic wr, b, fast_n, output logic q, en);
		write_select_n <= ~wr;
		// undriven data line toggles so stale values never match
		data_in <= wr ? b : ~data_in;
		tick(2);
		rw_strobe_n <= 1'h0;
		tick(3);
		fast_access_select_n <= fast_n;
		// a released pin reads back inverted so it never passes as data
		q = data_out_en ? data_out : ~data_out;
		en = data_out_en;
		tick(2);
		rw_strobe_n <= 1'h1;
		tick(3);
	endtask
	task automatic refresh();
		ext_refresh_strobe_n <= 1'h0;
		tick(2);
		ext_refresh_strobe_n <= 1'h1;
		tick(2);
	endtask
endmodule // host_model

/* tb/serial_bit_memory_sequencer_tb.sv */
// self-checking bench for the serial bit memory sequencer
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
	$display("ERROR %0t got %h want %h", $time, a, b); end end
module serial_bit_memory_sequencer_tb;
	import serial_bit_memory_pkg::*;
	logic CLOCK = 0, NRST = 0;
	wire rw_strobe_n, write_select_n, data_in, serial_addr_in, data_out;
	wire serial_addr_strobe, addr_transfer_strobe_n, data_out_en;
	wire count_direction_select, refresh_mode_select_n;
	wire ext_refresh_strobe_n, fast_access_select_n;
	status_t status;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	int failures = 0, tests_run = 0, seed = 32'h0a28, row, word;
	bit mem [int];
	bit fq[$];
	bit up = 1, fast, dir = 1, cap;
	always #10 CLOCK = ~CLOCK;
	host_model host (.clock(CLOCK), .data_out, .data_out_en, .rw_strobe_n,
		.write_select_n, .data_in, .serial_addr_in, .serial_addr_strobe,
		.addr_transfer_strobe_n, .count_direction_select,
		.refresh_mode_select_n, .ext_refresh_strobe_n, .fast_access_select_n);
	serial_bit_memory #(.REFRESH_TICK(8), .FIFO_DEPTH(16)) dut (
		.CLOCK(CLOCK), .NRST(NRST), .RW_STROBE_N(rw_strobe_n),
		.WRITE_SELECT_N(write_select_n), .DATA_IN(data_in),
		.DATA_OUT(data_out), .DATA_OUT_EN(data_out_en),
		.SERIAL_ADDR_IN(serial_addr_in),
		.SERIAL_ADDR_STROBE(serial_addr_strobe),
		.ADDR_TRANSFER_STROBE_N(addr_transfer_strobe_n),
		.COUNT_DIRECTION_SELECT(count_direction_select),
		.REFRESH_MODE_SELECT_N(refresh_mode_select_n),
		.EXT_REFRESH_STROBE_N(ext_refresh_strobe_n),
		.FAST_ACCESS_SELECT_N(fast_access_select_n), .STATUS(status),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	task automatic close_out();
		if (failures == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#2000000;
		failures++;
		close_out();
	end
	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge CLOCK);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		bready <= 1'h0;
		@(posedge CLOCK);
	endtask
	task automatic axr(input logic [3:0] a, output logic [31:0] d);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(posedge CLOCK);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		d = rdata;
		rready <= 1'h0;
		@(posedge CLOCK);
	endtask
	// word wraps carry into the row in the counting direction
	function automatic void step();
		word = (word + (up ? 1 : 1023)) % 1024;
		if (up && word == 0) row = (row + 1) % 256;
		if (!up && word == 1023) row = (row + 255) % 256;
	endfunction
	task automatic setd(input bit v);
		dir = v;
		host.count_direction_select <= v;
		if (!fast) up = v;
	endtask
	task automatic ld(input int r, input bit u);
		setd(u);
		host.load(10'(r));
		row = r;
		word = u ? 0 : 1023;
		`CHK(status.addr, mem_addr_t'({row[7:0], word[9:0]}))
	endtask
	task automatic cyc(input bit wr, input bit fast_n);
		logic b, q, en;
		int a;
		b = 1'($random(seed));
		a = row * 1024 + word;
		host.access(wr, b, fast_n, q, en);
		`CHK(en, ~wr)
		if (wr) mem[a] = b;
		else if (mem.exists(a)) begin
			`CHK(q, mem[a])
			if (cap && fq.size() < 16) fq.push_back(mem[a]);
		end
		step();
		fast = !fast_n;
		if (!fast) up = dir;
		`CHK(status.addr, mem_addr_t'({row[7:0], word[9:0]}))
		`CHK(status.fast, fast)
	endtask
	initial begin
		logic [31:0] d;
		logic [9:0] r0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata} = 40'h0;
		wstrb = 4'hf;
		repeat (16) @(posedge CLOCK);
		NRST <= 1'h1;
		@(posedge CLOCK);
		`CHK(status.count_up, 1'h1)
		axw(4'h0, 32'h1);
		ld(5, 1);
		repeat (1030) cyc(1, 1);
		ld(5, 1);
		cap = 1;
		repeat (1030) cyc(0, 1);
		cap = 0;
		axw(4'h0, 32'h0);
		axr(4'h4, d);
		`CHK(d[20], 1'h1)
		// full fifo drops bits, so only the first sixteen come back
		for (int i = 0; i < 17; i++) begin
			axr(4'hc, d);
			`CHK(d[31], 1'(i < 16))
			if (i < 16) `CHK(d[0], fq[i])
		end
		// lane 2 strobe off: the overrun clear must not land
		wstrb <= 4'hb;
		axw(4'h4, 32'h100000);
		wstrb <= 4'hf;
		axr(4'h4, d);
		`CHK(d[20], 1'h1)
		axw(4'h4, 32'h100000);
		axr(4'h4, d);
		`CHK(d[20], 1'h0)
		ld(6, 0);
		repeat (1026) cyc(0, 1);
		setd(1);
		repeat (3) cyc(0, 1);
		ld(5, 1);
		cyc(0, 0);
		setd(0);
		repeat (3) cyc(0, 0);
		repeat (3) cyc(0, 1);
		axr(4'h8, d);
		r0 = d[9:0];
		host.tick(100);
		axr(4'h8, d);
		`CHK(d[9:0] != r0, 1'h1)
		`CHK(status.self_refresh, 1'h1)
		host.refresh_mode_select_n <= 1'h1;
		host.tick(4);
		axr(4'h8, d);
		r0 = d[9:0];
		repeat (5) host.refresh();
		axr(4'h8, d);
		`CHK(d[9:0], 10'(r0 + 5))
		`CHK(status.self_refresh, 1'h0)
		axr(4'h2, d);
		`CHK(rresp, 2'h2)
		axw(4'h8, 32'h0);
		`CHK(bresp, 2'h2)
		close_out();
	end
endmodule // serial_bit_memory_sequencer_tb
